//--- logic/fpga_config_handshake.sv
// Purpose: Power-on and configuration handshake sequencer
// Assumes: Board pull-ups on status and done pins, active serial memory
// Notes:   Status and done pin outputs drive low only; high comes from the pull-ups
// Behaviour
// - During power-on reset, hold both pins low
// - Wait about 100 ms, release status, await high
// - Keep user I/O tri-stated after power-on reset
// - Weak pull-ups on before and during configuration
// - Stages run reset, configuration, then initialization
// - Done pin open-drain, driven low until data
// - Release done once data received without error (no error check here: done is released after CONFIG_BITS data bits)
// - Ignore done pin low once in user mode
// - Initialize only after done pin reads high
// - Configure only while chip enable is low
// - Chain output enables next device's chip enable
// - Chain output may float or be unused
// - Drive serial data out, receive serial data in

`timescale 1ns/100ps

module fpga_config_handshake #(
    parameter int POR_CYCLES  = cfg_handshake_pkg::POR_CYCLES_DEF,
    parameter int CONFIG_BITS = cfg_handshake_pkg::CONFIG_BITS_DEF,
    parameter int INIT_CYCLES = cfg_handshake_pkg::INIT_CYCLES_DEF
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       config_status_n_in,
    output logic            config_status_n_out,
    output logic            config_status_n_oe,
    input  wire logic       config_complete_in,
    output logic            config_complete_out,
    output logic            config_complete_oe,
    input  wire logic       chip_enable_n,
    output logic            chain_enable_out_n,
    output logic            serial_config_data_out,
    input  wire logic       serial_config_data_in,
    output logic [7:0]      config_byte,
    output logic            config_byte_valid,
    output logic            user_io_oe,
    output logic            user_io_pullup_en,
    output logic            user_mode
);
    import cfg_handshake_pkg::*;

    cfg_state_t          state;
    cfg_state_t          next_state;
    logic [COUNT_W-1:0]  count;
    logic [COUNT_W-1:0]  next_count;
    logic [7:0]          cmd_shift;
    logic [7:0]          next_cmd_shift;
    logic [7:0]          rx_shift;
    logic [7:0]          next_rx_shift;
    logic [7:0]          next_config_byte;
    logic                next_config_byte_valid;
    logic                next_chain_enable_out_n;
    logic [SYNC_W-1:0]   pins_sync;
    logic                status_s;
    logic                done_s;
    logic                ce_n_s;
    logic                sdi_s;
    logic [COUNT_W-1:0]  data_index;

    // Pin levels cross into mclk before any decision
    level_sync #(
        .WIDTH    (SYNC_W)
    ) u_pin_sync (
        .mclk     (mclk),
        .rst      (rst),
        .async_in ({serial_config_data_in, chip_enable_n,
                    config_complete_in, config_status_n_in}),
        .sync_out (pins_sync)
    );

    assign status_s   = pins_sync[0];
    assign done_s     = pins_sync[1];
    assign ce_n_s     = pins_sync[2];
    assign sdi_s      = pins_sync[3];
    assign data_index = count - COUNT_W'(CMD_BITS);

    // Open-drain pins only ever drive low
    assign config_status_n_out = 1'b0;
    assign config_complete_out = 1'b0;
    assign config_status_n_oe  = (state == ST_POR);
    assign config_complete_oe  = (state == ST_POR) || (state == ST_RELEASE)
                              || (state == ST_CONFIG);
    assign user_io_oe          = (state == ST_USER);
    assign user_io_pullup_en   = (state != ST_USER);
    assign user_mode           = (state == ST_USER);
    assign serial_config_data_out = cmd_shift[7];

    // Sequencer next-state and datapath
    always_comb begin
        next_state              = state;
        next_count              = count;
        next_cmd_shift          = cmd_shift;
        next_rx_shift           = rx_shift;
        next_config_byte        = config_byte;
        next_config_byte_valid  = 1'b0;
        unique case (state)
            ST_POR: begin
                // Long count is a parameter so simulation can shorten it
                if (count == COUNT_W'(POR_CYCLES - 1)) begin
                    next_state = ST_RELEASE;
                    next_count = '0;
                end else begin
                    next_count = count + 1'b1;
                end
            end
            ST_RELEASE: begin
                next_cmd_shift = READ_CMD;
                next_count     = '0;
                // Status pulled high and chip enabled
                if (status_s && !ce_n_s) begin
                    next_state = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                next_cmd_shift = {cmd_shift[6:0], 1'b0};
                next_count     = count + 1'b1;
                if (count >= COUNT_W'(CMD_BITS)) begin
                    next_rx_shift = {rx_shift[6:0], sdi_s};
                    if (data_index[2:0] == 3'h7) begin
                        next_config_byte       = {rx_shift[6:0], sdi_s};
                        next_config_byte_valid = 1'b1;
                    end
                end
                // Chip enable lost: restart the load rather than resume
                if (ce_n_s) begin
                    next_state = ST_RELEASE;
                end else if (count == COUNT_W'(CMD_BITS + CONFIG_BITS - 1)) begin
                    next_state = ST_WAIT_DONE;
                end
            end
            ST_WAIT_DONE: begin
                next_count = '0;
                // Done released; start only once pull-up makes it high
                if (done_s) begin
                    next_state = ST_INIT;
                end
            end
            ST_INIT: begin
                next_count = count + 1'b1;
                if (count == COUNT_W'(INIT_CYCLES - 1)) begin
                    next_state = ST_USER;
                end
            end
            ST_USER: begin
                // Done pin no longer watched
                next_state = ST_USER;
            end
        endcase
        // Chain output follows user mode; unused pin is harmless
        next_chain_enable_out_n = (next_state != ST_USER);
    end

    // Sequencer registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            state              <= ST_POR;
            count              <= '0;
            cmd_shift          <= '0;
            rx_shift           <= '0;
            config_byte        <= '0;
            config_byte_valid  <= 1'b0;
            chain_enable_out_n <= 1'b1;
        end else begin
            state              <= next_state;
            count              <= next_count;
            cmd_shift          <= next_cmd_shift;
            rx_shift           <= next_rx_shift;
            config_byte        <= next_config_byte;
            config_byte_valid  <= next_config_byte_valid;
            chain_enable_out_n <= next_chain_enable_out_n;
        end
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_POR_HOLD: assert property (state == ST_POR |-> config_status_n_oe && config_complete_oe
        && !user_io_oe) else $error("pins not held low in power-on reset");
    AST_STATUS_WAIT: assert property (state == ST_RELEASE && !status_s |=> state == ST_RELEASE
        && !config_status_n_oe) else $error("left release without status high");
    AST_IO_HIZ: assert property (state != ST_USER |-> !user_io_oe)
        else $error("user io driven before user mode");
    AST_PULLUP: assert property (!user_mode |-> user_io_pullup_en)
        else $error("pull-ups off before user mode");
    AST_ORDER: assert property (state == ST_INIT |-> $past(state) inside {ST_WAIT_DONE, ST_INIT})
        else $error("initialization out of order");
    AST_DONE_LOW: assert property (state == ST_CONFIG |-> config_complete_oe)
        else $error("done released during configuration");
    AST_DONE_RELEASE: assert property (state == ST_CONFIG ##1 state == ST_WAIT_DONE
        |-> !config_complete_oe) else $error("done not released");
    AST_USER_STICKY: assert property (state == ST_USER && !done_s |=> state == ST_USER
        && user_io_oe) else $error("user mode disturbed by done low");
    AST_INIT_WAIT: assert property (state == ST_WAIT_DONE && !done_s |=> state == ST_WAIT_DONE)
        else $error("initialized before done high");
    AST_CE_GATE: assert property (state == ST_RELEASE && ce_n_s |=> state != ST_CONFIG)
        else $error("configured without chip enable");
    AST_CHAIN: assert property ($rose(user_mode) |-> !chain_enable_out_n ##1 !chain_enable_out_n)
        else $error("chain output not asserted in user mode");
    AST_CMD_OUT: assert property (state == ST_RELEASE ##1 state == ST_CONFIG
        |-> cmd_shift == READ_CMD && serial_config_data_out == READ_CMD[7])
        else $error("command bit wrong");

    COV_USER: cover property (state == ST_INIT ##1 state == ST_USER);
    COV_BYTE: cover property (config_byte_valid);
    COV_CE_ABORT: cover property (state == ST_CONFIG ##1 state == ST_RELEASE);

endmodule : fpga_config_handshake

//--- logic/cfg_handshake_pkg.sv
// Purpose: Shared constants for the configuration handshake controller
// Assumes: 200 MHz mclk
// Notes:   Power-on reset count is derived from the time in its own unit

package cfg_handshake_pkg;

    // Clock rate and power-on reset duration
    localparam int CLK_MHZ        = 200;
    localparam int POR_TIME_MS    = 100;
    localparam int POR_CYCLES_DEF = POR_TIME_MS * 1000 * CLK_MHZ;

    // Counter width covers the full power-on reset count
    localparam int COUNT_W = 25;

    // Serial memory access: read command shifted out ahead of the data
    localparam int          CMD_BITS = 8;
    localparam logic [7:0]  READ_CMD = 8'h03;

    // Default bitstream length and initialization length, in cycles
    localparam int CONFIG_BITS_DEF = 1024;
    localparam int INIT_CYCLES_DEF = 16;

    // Number of synchronised pin levels
    localparam int SYNC_W = 4;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_POR,
        ST_RELEASE,
        ST_CONFIG,
        ST_WAIT_DONE,
        ST_INIT,
        ST_USER
    } cfg_state_t;

endpackage : cfg_handshake_pkg

//--- logic/level_sync.sv
// Purpose: Two-flop synchroniser for a group of pin levels
// Assumes: Inputs are asynchronous to mclk
// Notes:   First stage is read only by the second stage

`timescale 1ns/100ps

module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync;

    // One synchroniser per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                next_stage1[i] = async_in[i];
                next_sync[i]   = stage1[i];
            end
        end
    endgenerate

    // Reset to high: matches the idle level of the pulled-up pins
    always_ff @(posedge mclk) begin
        if (rst) begin
            stage1   <= '1;
            sync_out <= '1;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync;
        end
    end

endmodule : level_sync

//--- test/cfg_memory_model.sv
// Purpose: Board side of the pins: pull-ups and a serial configuration memory
// Assumes: Status and done pins pulled up; one data bit per mclk
// Notes:   Slow done pull-up is set by the bench to stress the wait
`timescale 1ns/100ps

module cfg_memory_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       status_oe,
    input  wire logic       done_oe,
    input  wire logic       sdo,
    input  wire logic       hold_status,
    input  wire logic       hold_done,
    input  wire logic [3:0] rise_delay,
    output logic            status_pin,
    output logic            done_pin,
    output logic            sdi,
    output logic            cmd_ok
);
    logic [7:0] cmd_sr;
    logic [3:0] rise_cnt;
    logic [7:0] next_sr;

    // Wired pin levels; a sink from either party wins over the pull-up
    assign status_pin = !(status_oe || hold_status);
    assign done_pin   = !(done_oe || hold_done) && (rise_cnt >= rise_delay);
    assign next_sr    = {cmd_sr[6:0], sdo};

    // Read command seen, then ones stream; idle line toggles so nothing stale passes
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmd_sr   <= 8'h00;
            cmd_ok   <= 1'b0;
            sdi      <= 1'b0;
            rise_cnt <= 4'h0;
        end else begin
            cmd_sr   <= next_sr;
            cmd_ok   <= cmd_ok || (next_sr == 8'h03);
            sdi      <= (cmd_ok || next_sr == 8'h03) ? 1'b1 : ~sdi;
            rise_cnt <= (done_oe || hold_done) ? 4'h0 : rise_cnt + {3'h0, rise_cnt != 4'hf};
        end
    end
endmodule : cfg_memory_model

//--- test/testbench.sv
// Purpose: Self-checking bench for the configuration handshake sequencer
// Assumes: Shortened counts; bench drives 1 ns after each rising edge
// Notes:   First byte after the command may be partial, so only later ones are judged
`timescale 1ns/100ps

module testbench;
    import cfg_handshake_pkg::*;
    localparam int POR_N  = 20;
    localparam int BITS_N = 32;
    localparam int INIT_N = 4;
    logic       mclk = 1'b0, rst = 1'b1, ce_n = 1'b0, hold_status = 1'b1, hold_done = 1'b0;
    logic [3:0] rise_delay = 4'h6;
    logic       status_pin, done_pin, sdi, cmd_ok, status_oe, done_oe, sdo, chain_n;
    logic       status_out, done_out;
    logic       cvalid, io_oe, pull_en, umode;
    logic [7:0] cbyte;
    int         bad_count = 0, n_checks = 0, cycles = 0, vcount = 0, ones = 0, n = 0;

    fpga_config_handshake #(.POR_CYCLES(POR_N), .CONFIG_BITS(BITS_N), .INIT_CYCLES(INIT_N))
    dut_u (.mclk(mclk), .rst(rst), .config_status_n_in(status_pin),
        .config_status_n_out(status_out), .config_status_n_oe(status_oe),
        .config_complete_in(done_pin), .config_complete_out(done_out),
        .config_complete_oe(done_oe), .chip_enable_n(ce_n), .chain_enable_out_n(chain_n),
        .serial_config_data_out(sdo), .serial_config_data_in(sdi), .config_byte(cbyte),
        .config_byte_valid(cvalid), .user_io_oe(io_oe), .user_io_pullup_en(pull_en),
        .user_mode(umode));

    cfg_memory_model mem_u (.mclk(mclk), .rst(rst), .status_oe(status_oe), .done_oe(done_oe),
        .sdo(sdo), .hold_status(hold_status), .hold_done(hold_done), .rise_delay(rise_delay),
        .status_pin(status_pin), .done_pin(done_pin), .sdi(sdi), .cmd_ok(cmd_ok));

    // Clock and a hang guard
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 3000) begin
            bad_count++;
            conclude();
        end
    end
    // Tally received bytes
    always @(posedge mclk) begin
        if (cvalid === 1'b1) begin
            vcount++;
            ones += (cbyte === 8'hff);
        end
    end

    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : step

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Pins held low and I/O quiet for the first POR_N - 1 cycles of the power-on count
    task automatic t_por();
        for (int i = 0; i < POR_N - 1; i++) begin
            check("status_oe", 1, status_oe);
            check("done_oe", 1, done_oe);
            check("status drive", 0, status_out);
            check("done drive", 0, done_out);
            check("io_oe", 0, io_oe);
            check("pullup", 1, pull_en);
            step(1);
        end
        for (int i = 0; i < 4 && status_oe !== 1'b0; i++) step(1);
        check("status released", 0, status_oe);
    endtask : t_por

    // Status held low externally, then chip enable high: no configuration
    task automatic t_blocked();
        step(20);
        check("bytes, status low", 0, 8'(vcount));
        hold_status = 1'b0;
        ce_n = 1'b1;
        step(20);
        check("bytes, ce high", 0, 8'(vcount));
        check("done_oe", 1, done_oe);
        ce_n = 1'b0;
    endtask : t_blocked

    // Chip enable lost in mid-load stops the load and keeps done low
    task automatic t_abort();
        for (int i = 0; i < 100 && vcount < 1; i++) step(1);
        ce_n = 1'b1;
        n = vcount;
        step(20);
        check("bytes after abort", 1, 8'(vcount <= n + 1));
        check("done_oe", 1, done_oe);
        vcount = 0;
        ones = 0;
        ce_n = 1'b0;
    endtask : t_abort

    // Full load, slow done pull-up, then user mode
    task automatic t_config();
        for (int i = 0; i < 200 && done_oe !== 1'b0; i++) begin
            check("user_mode early", 0, umode);
            step(1);
        end
        // Last valid pulse stands in the first wait cycle, so let it be tallied
        step(1);
        check("byte count", BITS_N / 8, 8'(vcount));
        check("last byte", 8'hff, cbyte);
        check("ones bytes", 1, 8'(ones >= 3));
        check("read command", 1, cmd_ok);
        for (int i = 0; i < 20 && done_pin !== 1'b1; i++) begin
            check("user_mode, done low", 0, umode);
            step(1);
        end
        for (n = 0; n < 20 && umode !== 1'b1; n++) step(1);
        check("init length", 1, 8'(n >= INIT_N && n <= INIT_N + 4));
        check("io_oe", 1, io_oe);
        check("pullup", 0, pull_en);
        check("chain out", 0, chain_n);
    endtask : t_config

    // Done sunk in user mode is ignored; then a second reset
    task automatic t_user();
        hold_done = 1'b1;
        step(10);
        check("user_mode", 1, umode);
        check("io_oe", 1, io_oe);
        hold_done = 1'b0;
        rst = 1'b1;
        step(2);
        check("status_oe", 1, status_oe);
        check("done_oe", 1, done_oe);
        check("user_mode", 0, umode);
        check("chain out", 1, chain_n);
    endtask : t_user

    task automatic conclude();
        $display("Checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    initial begin
        step(10);
        rst = 1'b0;
        t_por();
        t_blocked();
        t_abort();
        t_config();
        t_user();
        conclude();
    end
endmodule : testbench
